// >>> shared/asfr_pkg.sv
// condition flag register package: flag positions, register map, op codes
// assumes a 32-bit classic wishbone slave and an 8-bit alu datapath
package asfr_pkg;

	localparam int ASFR_DW     = 8;
	localparam int ASFR_FLAG_W = 5;

	// flag bit positions inside the register
	localparam int ASFR_BIT_CARRY = 0;
	localparam int ASFR_BIT_HALF  = 1;
	localparam int ASFR_BIT_ZERO  = 2;
	localparam int ASFR_BIT_WRAP  = 3;
	localparam int ASFR_BIT_NEG   = 4;

	// flags power up unknown on the part; this model picks all clear
	localparam logic [ASFR_FLAG_W-1:0] ASFR_FLAGS_RST = 5'h00;

	// byte offsets on the wishbone bus
	localparam logic [3:0] ASFR_OFS_FLAGS    = 4'h0;
	localparam logic [3:0] ASFR_OFS_RESULT   = 4'h4;
	localparam logic [3:0] ASFR_OFS_ACTIVITY = 4'h8;

	// fields of the activity register
	localparam int ASFR_ACT_OP_LSB      = 0;
	localparam int ASFR_ACT_DISCARD_LSB = 8;
	localparam int ASFR_ACT_UPDATE_LSB  = 16;

	localparam logic [ASFR_DW-1:0] ASFR_RESULT_RST = 8'h00;
	localparam logic [31:0]        ASFR_RD_ZERO    = 32'h0000_0000;

	typedef enum logic [3:0] {
		ASFR_ACCUMULATOR_PLUS_FILE_OP    = 4'h0,
		ASFR_ACCUMULATOR_PLUS_LITERAL_OP = 4'h1,
		ASFR_LITERAL_MINUS_ACCUMULATOR_OP = 4'h2,
		ASFR_FILE_MINUS_ACCUMULATOR_OP   = 4'h3,
		ASFR_AND_OP                      = 4'h4,
		ASFR_IOR_OP                      = 4'h5,
		ASFR_XOR_OP                      = 4'h6,
		ASFR_CLEAR_FILE_OP               = 4'h7,
		ASFR_BIT_CLEAR_OP                = 4'h8,
		ASFR_BIT_SET_OP                  = 4'h9,
		ASFR_NIBBLE_EXCHANGE_OP          = 4'ha,
		ASFR_FILE_COPY_OP                = 4'hb,
		ASFR_ACCUMULATOR_STORE_OP        = 4'hc,
		ASFR_ROTATE_RIGHT_CARRY_OP       = 4'hd,
		ASFR_ROTATE_LEFT_CARRY_OP        = 4'he,
		ASFR_PASS_OP                     = 4'hf
	} asfr_op_e;

	// which flags an operation owns; a zero mask leaves every flag alone unless the flag register is the destination
	function automatic logic [ASFR_FLAG_W-1:0] asfr_flag_mask(
		input asfr_op_e op);
		case (op)
			ASFR_ACCUMULATOR_PLUS_FILE_OP,
			ASFR_ACCUMULATOR_PLUS_LITERAL_OP,
			ASFR_LITERAL_MINUS_ACCUMULATOR_OP,
			ASFR_FILE_MINUS_ACCUMULATOR_OP: asfr_flag_mask = 5'h1f;
			ASFR_AND_OP,
			ASFR_IOR_OP,
			ASFR_XOR_OP:                    asfr_flag_mask = 5'h14;
			ASFR_CLEAR_FILE_OP:             asfr_flag_mask = 5'h04;
			ASFR_ROTATE_RIGHT_CARRY_OP,
			ASFR_ROTATE_LEFT_CARRY_OP:      asfr_flag_mask = 5'h15;
			default:                        asfr_flag_mask = 5'h00;
		endcase
	endfunction

endpackage

// >>> hw/asfr_op_class.sv
// operation classifier: flag ownership and result write-back decision
// assumes op code and destination select are valid together
`timescale 1ns/10ps
module asfr_op_class (
	input  wire asfr_pkg::asfr_op_e             op_in,
	input  wire logic                           dest_is_flags_in,
	output logic [asfr_pkg::ASFR_FLAG_W-1:0]    mask_out,
	output logic                                use_literal_out,
	output logic                                writes_result_out,
	output logic                                discard_out
);
	import asfr_pkg::*;

	always_comb begin
		mask_out = asfr_flag_mask(op_in);
		use_literal_out = (op_in == ASFR_ACCUMULATOR_PLUS_LITERAL_OP) ||
			(op_in == ASFR_LITERAL_MINUS_ACCUMULATOR_OP);
		// flag-owning op aimed at the flag register loses its result
		discard_out = dest_is_flags_in && (mask_out != 5'h00); // [RULE2]
		writes_result_out = !dest_is_flags_in;
	end

endmodule // asfr_op_class

// >>> hw/asfr_flag_calc.sv
// alu result and candidate flag values for one operation
// purely combinational; the caller merges flags through the op mask
`timescale 1ns/10ps
module asfr_flag_calc (
	input  wire asfr_pkg::asfr_op_e             op_in,
	input  wire logic [asfr_pkg::ASFR_DW-1:0]   acc_in,
	input  wire logic [asfr_pkg::ASFR_DW-1:0]   opnd_in,
	input  wire logic [2:0]                     bit_sel_in,
	input  wire logic                           carry_in,
	output logic [asfr_pkg::ASFR_DW-1:0]        result_out,
	output logic [asfr_pkg::ASFR_FLAG_W-1:0]    flags_out
);
	import asfr_pkg::*;

	// returns {wrap, half, carry, sum}
	function automatic logic [10:0] add8(input logic [7:0] a,
		input logic [7:0] b, input logic cin);
		logic [4:0] lo;
		logic [8:0] full;
		logic       wrap;
		lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		wrap = (a[7] == b[7]) && (full[7] != a[7]); // [RULE6]
		add8 = {wrap, lo[4], full[8], full[7:0]}; // [RULE5]
	endfunction

	logic [10:0] sum_w;
	logic        rot_c;

	always_comb begin
		sum_w = 11'h000;
		rot_c = carry_in;
		result_out = opnd_in;
		case (op_in)
			ASFR_ACCUMULATOR_PLUS_FILE_OP,
			ASFR_ACCUMULATOR_PLUS_LITERAL_OP: begin
				sum_w = add8(opnd_in, acc_in, 1'b0);
				result_out = sum_w[7:0];
			end
			// subtract adds the two's complement: carries are inverted borrows
			ASFR_LITERAL_MINUS_ACCUMULATOR_OP,
			ASFR_FILE_MINUS_ACCUMULATOR_OP: begin
				sum_w = add8(opnd_in, ~acc_in, 1'b1); // [RULE5]
				result_out = sum_w[7:0];
			end
			ASFR_AND_OP:             result_out = opnd_in & acc_in;
			ASFR_IOR_OP:             result_out = opnd_in | acc_in;
			ASFR_XOR_OP:             result_out = opnd_in ^ acc_in;
			ASFR_CLEAR_FILE_OP:      result_out = 8'h00;
			ASFR_BIT_CLEAR_OP:
				result_out = opnd_in & ~(8'h01 << bit_sel_in);
			ASFR_BIT_SET_OP:
				result_out = opnd_in | (8'h01 << bit_sel_in);
			ASFR_NIBBLE_EXCHANGE_OP:
				result_out = {opnd_in[3:0], opnd_in[7:4]};
			ASFR_ACCUMULATOR_STORE_OP: result_out = acc_in;
			ASFR_ROTATE_RIGHT_CARRY_OP: begin
				result_out = {carry_in, opnd_in[7:1]};
				rot_c = opnd_in[0]; // [RULE7]
			end
			ASFR_ROTATE_LEFT_CARRY_OP: begin
				result_out = {opnd_in[6:0], carry_in};
				rot_c = opnd_in[7]; // [RULE7]
			end
			default:                 result_out = opnd_in;
		endcase
		flags_out = 5'h00;
		flags_out[ASFR_BIT_NEG]   = result_out[7]; // [RULE7]
		flags_out[ASFR_BIT_ZERO]  = (result_out == 8'h00); // [RULE7]
		flags_out[ASFR_BIT_WRAP]  = sum_w[10];
		flags_out[ASFR_BIT_HALF]  = sum_w[9];
		flags_out[ASFR_BIT_CARRY] = sum_w[8];
		if ((op_in == ASFR_ROTATE_RIGHT_CARRY_OP) ||
			(op_in == ASFR_ROTATE_LEFT_CARRY_OP)) begin
			flags_out[ASFR_BIT_CARRY] = rot_c;
		end
	end

endmodule // asfr_flag_calc

// >>> hw/alu_status_flag_register.sv
// arithmetic condition flag register with wishbone access and alu port
// assumes op inputs synchronous to core_clk_in, one op per valid cycle
// Operation
// [RULE1] flag register usable as any instruction operand
// [RULE2] flag-owning op into flags drops result
// [RULE3] clear into flags sets zero, keeps rest
// [RULE4] bit, swap, copy, store ops keep flags
// [RULE5] add/sub: half and full carry, inverted borrow
// [RULE6] wrap flag on signed two's complement overflow
// [RULE7] negative is bit 7, zero on zero, rotate carry
`timescale 1ns/10ps
module alu_status_flag_register #(
	parameter int CNT_W = 8
) (
	input  wire logic                           core_clk_in,
	input  wire logic                           rst_in,
	input  wire logic                           wb_cyc_in,
	input  wire logic                           wb_stb_in,
	input  wire logic                           wb_we_in,
	input  wire logic [3:0]                     wb_adr_in,
	input  wire logic [3:0]                     wb_sel_in,
	input  wire logic [31:0]                    wb_dat_in,
	output logic [31:0]                         wb_dat_out,
	output logic                                wb_ack_out,
	input  wire logic                           op_valid_in,
	input  wire asfr_pkg::asfr_op_e             op_code_in,
	input  wire logic [asfr_pkg::ASFR_DW-1:0]   acc_in,
	input  wire logic [asfr_pkg::ASFR_DW-1:0]   file_in,
	input  wire logic [asfr_pkg::ASFR_DW-1:0]   literal_in,
	input  wire logic [2:0]                     bit_sel_in,
	input  wire logic                           src_is_flags_in,
	input  wire logic                           dest_is_flags_in,
	output logic [asfr_pkg::ASFR_DW-1:0]        result_out,
	output logic                                result_valid_out,
	output logic [asfr_pkg::ASFR_DW-1:0]        flags_out
);
	import asfr_pkg::*;

	// counters share one 32-bit activity word at byte lanes 1 and 2
	if (CNT_W < 1 || CNT_W > 8) begin : g_cnt_w_check
		$error("CNT_W must lie between 1 and 8");
	end

	logic [ASFR_FLAG_W-1:0] flags_r;
	logic [ASFR_FLAG_W-1:0] flags_nxt;
	logic [ASFR_DW-1:0]     result_r;
	logic                   result_valid_r;
	logic                   ack_r;
	logic [31:0]            rd_data_r;
	logic [31:0]            rd_data_nxt;
	logic [CNT_W-1:0]       discard_cnt_r;
	logic [CNT_W-1:0]       update_cnt_r;
	logic [3:0]             last_op_r;
	logic [ASFR_DW-1:0]     flags_word;
	logic [ASFR_DW-1:0]     opnd;
	logic [ASFR_DW-1:0]     calc_result;
	logic [ASFR_FLAG_W-1:0] calc_flags;
	logic [ASFR_FLAG_W-1:0] op_mask;
	logic                   use_literal;
	logic                   writes_result;
	logic                   discard;
	logic                   bus_req;
	logic                   bus_wr;
	logic                   wr_flags;
	logic                   wr_activity;
	logic                   flag_update;

	// upper three bits are unimplemented and always read zero
	assign flags_word = {3'b000, flags_r};

	// the flag register feeds the file operand like any other register
	always_comb begin
		if (use_literal) begin
			opnd = literal_in;
		end else if (src_is_flags_in) begin
			opnd = flags_word; // [RULE1]
		end else begin
			opnd = file_in;
		end
	end

	asfr_op_class u_op_class (
		.op_in             (op_code_in),
		.dest_is_flags_in  (dest_is_flags_in),
		.mask_out          (op_mask),
		.use_literal_out   (use_literal),
		.writes_result_out (writes_result),
		.discard_out       (discard)
	);

	asfr_flag_calc u_flag_calc (
		.op_in      (op_code_in),
		.acc_in     (acc_in),
		.opnd_in    (opnd),
		.bit_sel_in (bit_sel_in),
		.carry_in   (flags_r[ASFR_BIT_CARRY]),
		.result_out (calc_result),
		.flags_out  (calc_flags)
	);

	// wishbone: ack one cycle after the strobe, writes land on the ack edge
	assign bus_req     = wb_cyc_in && wb_stb_in;
	assign bus_wr      = bus_req && wb_we_in && ack_r;
	assign wr_flags    = bus_wr && (wb_adr_in == ASFR_OFS_FLAGS) &&
		wb_sel_in[0];
	assign wr_activity = bus_wr && (wb_adr_in == ASFR_OFS_ACTIVITY) &&
		(wb_sel_in != 4'h0);
	assign flag_update = op_valid_in && (op_mask != 5'h00);

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= bus_req && !ack_r;
		end
	end

	always_comb begin
		rd_data_nxt = ASFR_RD_ZERO;
		case (wb_adr_in)
			ASFR_OFS_FLAGS:  rd_data_nxt[ASFR_DW-1:0] = flags_word; // [RULE1]
			ASFR_OFS_RESULT: rd_data_nxt[ASFR_DW-1:0] = result_r;
			ASFR_OFS_ACTIVITY: begin
				rd_data_nxt[ASFR_ACT_OP_LSB +: 4] = last_op_r;
				rd_data_nxt[ASFR_ACT_DISCARD_LSB +: CNT_W] = discard_cnt_r;
				rd_data_nxt[ASFR_ACT_UPDATE_LSB +: CNT_W] = update_cnt_r;
			end
			// unmapped offsets still ack, with zero data
			default:         rd_data_nxt = ASFR_RD_ZERO;
		endcase
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rd_data_r <= ASFR_RD_ZERO;
		end else if (bus_req && !ack_r) begin
			rd_data_r <= rd_data_nxt;
		end
	end

	// flag register: the alu wins over a software write in the same cycle,
	// since a lost hardware update would corrupt a branch decision
	always_comb begin
		flags_nxt = flags_r;
		if (wr_flags) begin
			flags_nxt = wb_dat_in[ASFR_FLAG_W-1:0]; // [RULE1]
		end
		if (op_valid_in) begin
			if (flag_update) begin
				// only owned flags move; clear into flags touches zero only
				flags_nxt = (flags_r & ~op_mask) |
					(calc_flags & op_mask); // [RULE2] [RULE3]
			end else if (dest_is_flags_in) begin
				// bit, swap, copy and store write the value itself
				flags_nxt = calc_result[ASFR_FLAG_W-1:0]; // [RULE4]
			end
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			flags_r <= ASFR_FLAGS_RST;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	// result write-back towards the register file
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			result_r       <= ASFR_RESULT_RST;
			result_valid_r <= 1'b0;
		end else begin
			result_valid_r <= op_valid_in && writes_result;
			if (op_valid_in && writes_result) begin
				result_r <= calc_result;
			end
		end
	end

	// activity counters wrap; an event in the clearing cycle is kept
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			discard_cnt_r <= '0;
		end else if (wr_activity) begin
			discard_cnt_r <= CNT_W'(op_valid_in && discard);
		end else if (op_valid_in && discard) begin
			discard_cnt_r <= discard_cnt_r + CNT_W'(1);
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			update_cnt_r <= '0;
		end else if (wr_activity) begin
			update_cnt_r <= CNT_W'(flag_update);
		end else if (flag_update) begin
			update_cnt_r <= update_cnt_r + CNT_W'(1);
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			last_op_r <= 4'h0;
		end else if (op_valid_in) begin
			last_op_r <= op_code_in;
		end
	end

	// flags_out is the registered view, never the combinational next value
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			flags_out <= {3'b000, ASFR_FLAGS_RST};
		end else begin
			flags_out <= {3'b000, flags_nxt};
		end
	end

	assign wb_ack_out       = ack_r;
	assign wb_dat_out       = rd_data_r;
	assign result_out       = result_r;
	assign result_valid_out = result_valid_r;

endmodule // alu_status_flag_register

// >>> sim/asfr_monitor.sv
// checker for the flag register: bus handshake and flag update relations
// assumes it is bound to alu_status_flag_register with one clock domain
`timescale 1ns/10ps
module asfr_monitor #(
	parameter int CNT_W = 8
) (
	input wire logic               core_clk_in,
	input wire logic               rst_in,
	input wire logic               wb_cyc_in,
	input wire logic               wb_stb_in,
	input wire logic               wb_we_in,
	input wire logic               wb_ack_out,
	input wire logic               op_valid_in,
	input wire asfr_pkg::asfr_op_e op_code_in,
	input wire logic [7:0]         acc_in,
	input wire logic [7:0]         file_in,
	input wire logic               src_is_flags_in,
	input wire logic               dest_is_flags_in,
	input wire logic [7:0]         result_out,
	input wire logic               result_valid_out,
	input wire logic [7:0]         flags_out
);
	import asfr_pkg::*;
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	logic [8:0] sum9;
	logic [4:0] sum5;
	logic [1:0] add_ch;
	logic       add_wrap;
	logic       add_op;
	logic       owns;
	logic       keeps;
	logic       nz_op;
	assign sum9 = {1'b0, acc_in} + {1'b0, file_in};
	assign sum5 = {1'b0, acc_in[3:0]} + {1'b0, file_in[3:0]};
	assign add_ch = {sum5[4], sum9[8]};
	assign add_wrap = (acc_in[7] == file_in[7]) && (sum9[7] != acc_in[7]);
	assign add_op = op_valid_in && !src_is_flags_in && !dest_is_flags_in
		&& op_code_in == ASFR_ACCUMULATOR_PLUS_FILE_OP;
	assign owns = op_code_in <= ASFR_CLEAR_FILE_OP
		|| op_code_in inside {ASFR_ROTATE_RIGHT_CARRY_OP,
			ASFR_ROTATE_LEFT_CARRY_OP};
	assign keeps = op_code_in inside {[ASFR_BIT_CLEAR_OP:ASFR_ACCUMULATOR_STORE_OP]};
	// clear owns only zero, so its result says nothing of the sign flag
	assign nz_op = owns && op_code_in != ASFR_CLEAR_FILE_OP;
	sequence wb_req;
		wb_cyc_in && wb_stb_in && !wb_ack_out;
	endsequence
	sequence ack_once;
		wb_ack_out ##1 !wb_ack_out;
	endsequence
	wb_ack_pulse_a: assert property (wb_req |=> ack_once)
		else $error("bus ack not a single pulse after request");
	upper_zero_a: assert property (flags_out[7:5] == 3'h0)
		else $error("flag register upper bits not zero");
	result_drop_a: assert property (
		op_valid_in && dest_is_flags_in && owns
		|=> !result_valid_out && $stable(result_out))
		else $error("result written although destination is flags");
	result_write_a: assert property (
		op_valid_in && !dest_is_flags_in |=> result_valid_out)
		else $error("result not written back");
	clear_zero_a: assert property (
		op_valid_in && dest_is_flags_in && op_code_in == ASFR_CLEAR_FILE_OP
		|=> flags_out == ($past(flags_out) | 8'h04))
		else $error("clear into flags did not set only zero");
	keep_flags_a: assert property (
		op_valid_in && keeps && !dest_is_flags_in
		&& !(wb_we_in && wb_ack_out) |=> $stable(flags_out))
		else $error("flag-neutral op changed flags");
	add_carry_a: assert property (
		add_op |=> flags_out[1:0] == $past(add_ch))
		else $error("add carry or half carry wrong");
	add_wrap_a: assert property (
		add_op |=> flags_out[3] == $past(add_wrap))
		else $error("add wrap flag wrong");
	neg_zero_a: assert property (
		op_valid_in && nz_op && !dest_is_flags_in
		|=> flags_out[4] == result_out[7] && flags_out[2] == (result_out == 8'h00))
		else $error("negative or zero flag disagrees with result");
endmodule // asfr_monitor

bind alu_status_flag_register asfr_monitor #(.CNT_W(CNT_W)) u_asfr_monitor (
	.core_clk_in(core_clk_in), .rst_in(rst_in), .wb_cyc_in(wb_cyc_in),
	.wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_ack_out(wb_ack_out),
	.op_valid_in(op_valid_in), .op_code_in(op_code_in), .acc_in(acc_in),
	.file_in(file_in), .src_is_flags_in(src_is_flags_in),
	.dest_is_flags_in(dest_is_flags_in), .result_out(result_out),
	.result_valid_out(result_valid_out), .flags_out(flags_out));

// >>> sim/asfr_alu_model.sv
// alu-side partner: issues one operation per call, valid for one cycle
// assumes the block samples the op inputs at the rising edge
`timescale 1ns/10ps
module asfr_alu_model (
	input  wire logic         core_clk_in,
	output logic              op_valid_out,
	output asfr_pkg::asfr_op_e op_code_out,
	output logic [7:0]        acc_out,
	output logic [7:0]        file_out,
	output logic [7:0]        literal_out,
	output logic [2:0]        bit_sel_out,
	output logic              src_flags_out,
	output logic              dest_flags_out
);
	import asfr_pkg::*;
	initial begin
		op_valid_out = 1'b0;
		op_code_out = ASFR_PASS_OP;
		{acc_out, file_out, literal_out} = 24'h5a_a5_3c;
		{bit_sel_out, src_flags_out, dest_flags_out} = 5'h00;
	end
	task automatic issue(input asfr_op_e op, input logic [7:0] a,
		input logic [7:0] b, input logic d);
		@(posedge core_clk_in);
		op_valid_out <= 1'b1;
		op_code_out <= op;
		acc_out <= a;
		file_out <= b;
		literal_out <= b;
		bit_sel_out <= b[2:0];
		dest_flags_out <= d;
		@(posedge core_clk_in);
		op_valid_out <= 1'b0;
		// stale operands are inverted so a late sample cannot pass
		acc_out <= ~a;
		file_out <= ~b;
		literal_out <= ~b;
	endtask
endmodule // asfr_alu_model

// >>> sim/tb_top.sv
// self-checking bench: wishbone register access and alu op sequences
// assumes asfr_alu_model stands on the alu port of the block
`timescale 1ns/10ps
module tb_top;
	import asfr_pkg::*;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [3:0]  adr = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat, rd;
	logic        ack, opv, srcf, dstf, rvld;
	asfr_op_e    opc;
	logic [7:0]  acc, fil, lit, res, fl, eres;
	logic [2:0]  bsel;
	logic [4:0]  efl;
	int          err_total = 0;
	int          num_checks = 0;
	logic [3:0]  opn[12] = '{4'h0, 4'h1, 4'h0, 4'h1, 4'h2, 4'h3, 4'h3,
		4'h4, 4'h5, 4'h6, 4'hd, 4'he};
	logic [7:0]  av[12] = '{8'h0f, 8'h7f, 8'hff, 8'h80, 8'h01, 8'h05,
		8'h01, 8'hf0, 8'h80, 8'h55, 8'h01, 8'h80};
	logic [7:0]  bv[12] = '{8'h01, 8'h01, 8'h01, 8'h80, 8'h10, 8'h05,
		8'h00, 8'h0f, 8'h01, 8'h55, 8'h01, 8'h80};
	always #12.5 core_clk = ~core_clk;
	alu_status_flag_register u_alu_status_flag_register (
		.core_clk_in(core_clk), .rst_in(rst), .wb_cyc_in(cyc),
		.wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
		.wb_sel_in(4'hf), .wb_dat_in(wdat), .wb_dat_out(rdat),
		.wb_ack_out(ack), .op_valid_in(opv), .op_code_in(opc),
		.acc_in(acc), .file_in(fil), .literal_in(lit),
		.bit_sel_in(bsel), .src_is_flags_in(srcf),
		.dest_is_flags_in(dstf), .result_out(res),
		.result_valid_out(rvld), .flags_out(fl));
	asfr_alu_model u_asfr_alu_model (
		.core_clk_in(core_clk), .op_valid_out(opv), .op_code_out(opc),
		.acc_out(acc), .file_out(fil), .literal_out(lit),
		.bit_sel_out(bsel), .src_flags_out(srcf), .dest_flags_out(dstf));
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		bit hit;
		hit = 1'b0;
		@(posedge core_clk);
		{cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
		// ack and read data are taken at the rising edge where ack stands
		for (int i = 0; i < 8 && !hit; i++) begin
			@(posedge core_clk);
			hit = (ack === 1'b1);
			if (hit) rd = rdat;
		end
		{cyc, stb, we} <= 3'b000;
		if (!hit) begin
			err_total++;
			$display("MISMATCH wb_ack expected 1 seen 0");
			tally_and_finish();
		end
	endtask
	// independent flag model; subtract adds the inverted accumulator plus one
	function automatic logic [12:0] calc(input asfr_op_e op,
		input logic [7:0] a, input logic [7:0] b, input logic [4:0] f);
		logic       sb, nz;
		logic [7:0] ia, y;
		logic [8:0] s;
		logic [4:0] h, n;
		sb = op inside {ASFR_LITERAL_MINUS_ACCUMULATOR_OP,
			ASFR_FILE_MINUS_ACCUMULATOR_OP};
		ia = sb ? ~a : a;
		s = {1'b0, b} + {1'b0, ia} + 9'(sb);
		h = {1'b0, b[3:0]} + {1'b0, ia[3:0]} + 5'(sb);
		{n, nz, y} = {f, 1'b1, b};
		case (op)
			ASFR_AND_OP: y = a & b;
			ASFR_IOR_OP: y = a | b;
			ASFR_XOR_OP: y = a ^ b;
			ASFR_ROTATE_RIGHT_CARRY_OP: {y, n[0]} = {f[0], b};
			ASFR_ROTATE_LEFT_CARRY_OP: {n[0], y} = {b, f[0]};
			ASFR_CLEAR_FILE_OP: {y, nz, n[2]} = 10'h001;
			default: begin
				nz = op <= ASFR_FILE_MINUS_ACCUMULATOR_OP;
				if (nz) begin
					{n[0], y} = s;
					n[1] = h[4];
					n[3] = (b[7] == ia[7]) && (y[7] != b[7]);
				end
			end
		endcase
		if (nz) begin
			n[4] = y[7];
			n[2] = (y == 8'h00);
		end
		return {y, n};
	endfunction
	task automatic run(input asfr_op_e op, input logic [7:0] a,
		input logic [7:0] b, input logic d);
		logic [12:0] x;
		x = calc(op, a, b, efl);
		u_asfr_alu_model.issue(op, a, b, d);
		#1;
		efl = x[4:0];
		if (!d) eres = x[12:5];
	endtask
	initial begin
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		#1;
		chk("flags_reset", 32'h0, fl);
		wb(1'b1, ASFR_OFS_FLAGS, 32'hff);
		wb(1'b0, ASFR_OFS_FLAGS, 32'h0);
		chk("flags_read", 32'h1f, rd);
		wb(1'b0, 4'hc, 32'h0);
		chk("unmapped_read", 32'h0, rd);
		wb(1'b1, ASFR_OFS_FLAGS, 32'h0);
		efl = 5'h00;
		for (int i = 0; i < 12; i++) begin
			run(asfr_op_e'(opn[i]), av[i], bv[i], 1'b0);
			chk("result", eres, res);
			chk("flags", efl, fl);
			chk("result_valid", 32'h1, rvld);
		end
		wb(1'b0, ASFR_OFS_RESULT, 32'h0);
		chk("result_read", eres, rd);
		wb(1'b1, ASFR_OFS_FLAGS, 32'h0);
		efl = 5'h00;
		run(ASFR_ACCUMULATOR_PLUS_FILE_OP, 8'hff, 8'h01, 1'b1);
		chk("flags_discard", 32'h07, fl);
		chk("result_kept", eres, res);
		chk("no_result_valid", 32'h0, rvld);
		wb(1'b0, ASFR_OFS_ACTIVITY, 32'h0);
		chk("discard_count", 32'h01, rd[15:8]);
		wb(1'b1, ASFR_OFS_FLAGS, 32'h1b);
		#1;
		chk("flags_write", 32'h1b, fl);
		efl = 5'h1b;
		run(ASFR_CLEAR_FILE_OP, 8'h55, 8'h55, 1'b1);
		chk("flags_clear", 32'h1f, fl);
		chk("result_clear_kept", eres, res);
		for (int k = 8; k <= 12; k++) begin
			run(asfr_op_e'(k[3:0]), 8'h3c, 8'h3c, 1'b0);
			chk("flags_neutral", 32'h1f, fl);
		end
		// the flag register itself as the file operand of a pass op
		u_asfr_alu_model.src_flags_out <= 1'b1;
		run(ASFR_PASS_OP, 8'h00, 8'h00, 1'b0);
		chk("flags_operand", 32'h1f, res);
		u_asfr_alu_model.src_flags_out <= 1'b0;
		tally_and_finish();
	end
endmodule // tb_top
